// ===== shared/uart_ier_consts.svh
// Purpose: constants of the interrupt-enable / divisor-high block
// Assumes: 32-bit APB, byte addresses as printed
// Notes:   offsets, field positions, reset values and timing counts
`ifndef UART_IER_CONSTS_SVH
`define UART_IER_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define UART_ADDR_DIV_LOW    32'h5000_1000
`define UART_ADDR_IER_DLH    32'h5000_1004
`define UART_ADDR_LINE_CTRL  32'h5000_100c
`define UART_ADDR_IRQ_STAT   32'h5000_1014
`define UART_ADDR_IRQ_MASK   32'h5000_1018

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IER_RX_DATA_BIT      0
`define IER_TX_EMPTY_BIT     1
`define IER_RX_LINE_BIT      2
`define IER_MODEM_BIT        3
`define IER_PROG_MODE_BIT    7
`define DIV_ACCESS_BIT       7
`define IRQ_SRC_COUNT        4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IER_RESET            8'h00
`define DIV_LOW_RESET        8'h00
`define DIV_HIGH_RESET       8'h00
`define LINE_CTRL_RESET      8'h00
`define IRQ_STAT_RESET       4'h0
`define IRQ_MASK_RESET       4'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BAUD_OVERSAMPLE_LAST 4'hf
`define DIV_ZERO             16'h0000
`define DIV_ONE              16'h0001

`endif

// ===== shared/uart_ier_pkg.sv
// Purpose: types of the interrupt-enable / divisor-high block
// Assumes: constants live in uart_ier_consts.svh
// Notes:   nothing here is imported; users write uart_ier_pkg::name
package uart_ier_pkg;

   // ----------------------------------------------------------------
   // register select
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SEL_NONE      = 3'h0,
      SEL_DIV_LOW   = 3'h1,
      SEL_IER_DLH   = 3'h2,
      SEL_LINE_CTRL = 3'h3,
      SEL_IRQ_STAT  = 3'h4,
      SEL_IRQ_MASK  = 3'h5
   } reg_sel_t;

   // ----------------------------------------------------------------
   // highest pending interrupt source
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ID_NONE     = 3'h0,
      ID_RX_LINE  = 3'h1,
      ID_RX_DATA  = 3'h2,
      ID_TX_EMPTY = 3'h3,
      ID_MODEM    = 3'h4
   } int_id_t;

endpackage : uart_ier_pkg

// ===== shared/baud_if.sv
// Purpose: divisor and baud ticks between register file and generator
// Assumes: single clock domain
// Notes:   tick outputs are registered in the generator
`timescale 1ns/10ps
interface baud_if;
   logic [15:0] divisor;
   logic        tick16;
   logic        tick;
   logic        running;

   modport ctrl (output divisor, input tick16, input tick, input running);
   modport gen  (input divisor, output tick16, output tick, output running);
endinterface : baud_if

// ===== rtl/baud_gen.sv
// Purpose: 16x oversample and bit-rate ticks from the 16-bit divisor
// Assumes: divisor is a register value, stable for many cycles
// Notes:   a zero divisor parks the generator
`timescale 1ns/10ps
`include "uart_ier_consts.svh"
module baud_gen (
   // clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // divisor in, ticks out
   baud_if.gen       baud
);
   logic [15:0] count_r;
   logic [3:0]  phase_r;

   // ----------------------------------------------------------------
   // oversample divider
   // ----------------------------------------------------------------
   // one tick16 every divisor clocks, bit tick every sixteenth tick16
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         count_r      <= `DIV_ZERO;
         baud.tick16  <= 1'b0;
      end else if (baud.divisor == `DIV_ZERO) begin
         count_r      <= `DIV_ZERO;
         baud.tick16  <= 1'b0;
      end else if (count_r >= baud.divisor - `DIV_ONE) begin
         // >= also recovers at once when the divisor shrinks
         count_r      <= `DIV_ZERO;
         baud.tick16  <= 1'b1;
      end else begin
         count_r      <= count_r + `DIV_ONE;
         baud.tick16  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // bit-rate divider
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         phase_r   <= 4'h0;
         baud.tick <= 1'b0;
      end else if (baud.divisor == `DIV_ZERO) begin
         phase_r   <= 4'h0;
         baud.tick <= 1'b0;
      end else if (baud.tick16) begin
         phase_r   <= phase_r + 4'h1;
         baud.tick <= (phase_r == `BAUD_OVERSAMPLE_LAST);
      end else begin
         baud.tick <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         baud.running <= 1'b0;
      end else begin
         baud.running <= (baud.divisor != `DIV_ZERO);
      end
   end
endmodule : baud_gen

// ===== rtl/uart_ier_dlh.sv
// Purpose: interrupt-enable / divisor-high register of a UART, APB side
// Assumes: event inputs synchronous to clock; APB master obeys protocol
// Notes:   one wait state on every APB access
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`include "uart_ier_consts.svh"
module uart_ier_dlh (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // interrupt sources from the uart core
   input  wire logic        rxLineStatusEvt,
   input  wire logic        rxDataAvailEvt,
   input  wire logic        charTimeoutEvt,
   input  wire logic        fifoEnabled,
   input  wire logic        txHoldEmpty,
   input  wire logic        txBelowThreshold,
   input  wire logic        modemStatusEvt,
   // interrupt out
   output logic             irq,
   output logic [2:0]       intId,
   // control to the uart core
   output logic             progTxEmptyModeEn,
   output logic             divisorAccessBit,
   output logic [15:0]      divisorValue,
   // baud ticks
   output logic             baudTick16,
   output logic             baudTick,
   output logic             serialEnable
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]                ier_r;
   logic [7:0]                divLow_r;
   logic [7:0]                divHigh_r;
   logic [7:0]                lineCtrl_r;
   logic [`IRQ_SRC_COUNT-1:0] status_r;
   logic [`IRQ_SRC_COUNT-1:0] mask_r;
   logic [`IRQ_SRC_COUNT-1:0] event_nxt;
   logic [`IRQ_SRC_COUNT-1:0] clear_nxt;
   logic [`IRQ_SRC_COUNT-1:0] pending;
   logic [31:0]               rdata_nxt;
   logic                      access;
   logic                      wrDone;
   logic                      divAccess;
   logic                      txSource;
   uart_ier_pkg::reg_sel_t    sel;

   baud_if baud ();

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic uart_ier_pkg::reg_sel_t decodeAddr(
      input logic [31:0] addr);
      case (addr)
         `UART_ADDR_DIV_LOW:   decodeAddr = uart_ier_pkg::SEL_DIV_LOW;
         `UART_ADDR_IER_DLH:   decodeAddr = uart_ier_pkg::SEL_IER_DLH;
         `UART_ADDR_LINE_CTRL: decodeAddr = uart_ier_pkg::SEL_LINE_CTRL;
         `UART_ADDR_IRQ_STAT:  decodeAddr = uart_ier_pkg::SEL_IRQ_STAT;
         `UART_ADDR_IRQ_MASK:  decodeAddr = uart_ier_pkg::SEL_IRQ_MASK;
         default:              decodeAddr = uart_ier_pkg::SEL_NONE;
      endcase
   endfunction : decodeAddr

   assign sel       = decodeAddr(paddr);
   assign divAccess = lineCtrl_r[`DIV_ACCESS_BIT];
   // first access cycle prepares the answer, second completes it
   assign access    = psel & penable & ~pready;
   assign wrDone    = psel & penable & pready & pwrite;

   // ----------------------------------------------------------------
   // apb handshake and read data
   // ----------------------------------------------------------------
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (sel)
         uart_ier_pkg::SEL_DIV_LOW: begin
            // outside divisor access this offset belongs to the data path
            if (divAccess) begin
               rdata_nxt[7:0] = divLow_r;
            end
         end
         uart_ier_pkg::SEL_IER_DLH: begin
            if (divAccess) begin
               rdata_nxt[7:0] = divHigh_r;
            end else begin
               rdata_nxt[7:0] = ier_r;
            end
         end
         uart_ier_pkg::SEL_LINE_CTRL: rdata_nxt[7:0] = lineCtrl_r;
         uart_ier_pkg::SEL_IRQ_STAT:
            rdata_nxt[`IRQ_SRC_COUNT-1:0] = status_r;
         uart_ier_pkg::SEL_IRQ_MASK:
            rdata_nxt[`IRQ_SRC_COUNT-1:0] = mask_r;
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
      end else begin
         pready <= access;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (access) begin
         prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
         pslverr <= (sel == uart_ier_pkg::SEL_NONE);
      end
   end

   // ----------------------------------------------------------------
   // enable / divisor high register
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ier_r <= `IER_RESET;
      end else if (wrDone && sel == uart_ier_pkg::SEL_IER_DLH &&
                   !divAccess && pstrb[0]) begin
         // reserved field 6:4 is not stored in the enable view
         ier_r <= {pwdata[`IER_PROG_MODE_BIT], 3'h0, pwdata[3:0]};
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         divHigh_r <= `DIV_HIGH_RESET;
      end else if (wrDone && sel == uart_ier_pkg::SEL_IER_DLH &&
                   divAccess && pstrb[0]) begin
         divHigh_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         divLow_r <= `DIV_LOW_RESET;
      end else if (wrDone && sel == uart_ier_pkg::SEL_DIV_LOW &&
                   divAccess && pstrb[0]) begin
         divLow_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         lineCtrl_r <= `LINE_CTRL_RESET;
      end else if (wrDone && sel == uart_ier_pkg::SEL_LINE_CTRL &&
                   pstrb[0]) begin
         lineCtrl_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mask_r <= `IRQ_MASK_RESET;
      end else if (wrDone && sel == uart_ier_pkg::SEL_IRQ_MASK &&
                   pstrb[0]) begin
         mask_r <= pwdata[`IRQ_SRC_COUNT-1:0];
      end
   end

   // ----------------------------------------------------------------
   // interrupt sources
   // ----------------------------------------------------------------
   // in programmable mode the tx source follows the fifo threshold
   assign txSource = ier_r[`IER_PROG_MODE_BIT] ? txBelowThreshold
                                           : txHoldEmpty;

   always_comb begin
      event_nxt = `IRQ_STAT_RESET;
      event_nxt[`IER_RX_DATA_BIT]  = ier_r[`IER_RX_DATA_BIT] &
         (rxDataAvailEvt | (fifoEnabled & charTimeoutEvt));
      event_nxt[`IER_TX_EMPTY_BIT] =
         ier_r[`IER_TX_EMPTY_BIT] & txSource;
      event_nxt[`IER_RX_LINE_BIT]  =
         ier_r[`IER_RX_LINE_BIT] & rxLineStatusEvt;
      event_nxt[`IER_MODEM_BIT]    =
         ier_r[`IER_MODEM_BIT] & modemStatusEvt;
   end

   assign clear_nxt = (wrDone && sel == uart_ier_pkg::SEL_IRQ_STAT &&
                       pstrb[0]) ? pwdata[`IRQ_SRC_COUNT-1:0]
                                 : `IRQ_STAT_RESET;

   // sticky status; a new event beats a clear in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < `IRQ_SRC_COUNT; gi = gi + 1) begin : g_status
         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               status_r[gi] <= 1'b0;
            end else begin
               status_r[gi] <= event_nxt[gi] |
                               (status_r[gi] & ~clear_nxt[gi]);
            end
         end
      end
   endgenerate

   assign pending = status_r & mask_r;

   // ----------------------------------------------------------------
   // interrupt output and priority
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         irq   <= 1'b0;
         intId <= uart_ier_pkg::ID_NONE;
      end else begin
         irq <= |pending;
         if (pending[`IER_RX_LINE_BIT]) begin
            intId <= uart_ier_pkg::ID_RX_LINE;
         end else if (pending[`IER_RX_DATA_BIT]) begin
            intId <= uart_ier_pkg::ID_RX_DATA;
         end else if (pending[`IER_TX_EMPTY_BIT]) begin
            intId <= uart_ier_pkg::ID_TX_EMPTY;
         end else if (pending[`IER_MODEM_BIT]) begin
            intId <= uart_ier_pkg::ID_MODEM;
         end else begin
            intId <= uart_ier_pkg::ID_NONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // control outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         progTxEmptyModeEn <= 1'b0;
         divisorAccessBit  <= 1'b0;
         divisorValue      <= `DIV_ZERO;
      end else begin
         progTxEmptyModeEn <= ier_r[`IER_PROG_MODE_BIT];
         divisorAccessBit  <= divAccess;
         divisorValue      <= {divHigh_r, divLow_r};
      end
   end

   // ----------------------------------------------------------------
   // baud generator
   // ----------------------------------------------------------------
   assign baud.divisor = {divHigh_r, divLow_r};

   baud_gen u_baud_gen (
      .clock (clock),
      .reset (reset),
      .baud  (baud.gen)
   );

   // one more stage keeps every top output on a local flop
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         baudTick16   <= 1'b0;
         baudTick     <= 1'b0;
         serialEnable <= 1'b0;
      end else begin
         baudTick16   <= baud.tick16;
         baudTick     <= baud.tick;
         serialEnable <= baud.running;
      end
   end
endmodule : uart_ier_dlh

// ===== testbench/uart_ier_dlh_asserts.sv
// Purpose: port-level checks of the interrupt-enable / divisor-high block
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   bound to every instance of uart_ier_dlh
`timescale 1ns/10ps
`include "uart_ier_consts.svh"
module uart_ier_dlh_asserts (
   // clock and reset
   input wire logic        clock,
   input wire logic        reset,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // core side
   input wire logic        irq,
   input wire logic [2:0]  intId,
   input wire logic        progTxEmptyModeEn,
   input wire logic        divisorAccessBit,
   input wire logic [15:0] divisorValue,
   input wire logic        baudTick16,
   input wire logic        baudTick,
   input wire logic        serialEnable
);
   logic       wrIer;
   logic       wrLine;
   logic       mapped;
   logic [7:0] wrHigh_r;

   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   assign wrIer  = pready && pwrite && pstrb[0]
                   && paddr == `UART_ADDR_IER_DLH;
   assign wrLine = pready && pwrite && paddr == `UART_ADDR_LINE_CTRL;
   assign mapped = paddr inside {`UART_ADDR_DIV_LOW, `UART_ADDR_IER_DLH,
                   `UART_ADDR_LINE_CTRL, `UART_ADDR_IRQ_STAT,
                   `UART_ADDR_IRQ_MASK};

   // last byte written in divisor view, the value the high byte must take
   always_ff @(posedge clock or posedge reset) begin
      if (reset) wrHigh_r <= 8'h00;
      else if (wrIer && divisorAccessBit) wrHigh_r <= pwdata[7:0];
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_one_wait;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("pready not one cycle after one wait state");

   property p_unmapped;
      pready && !mapped |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");

   property p_prog_mode_src;
      $changed(progTxEmptyModeEn) |-> $past(wrIer && !divisorAccessBit)
         || $past(wrIer && !divisorAccessBit, 2);
   endproperty
   a_prog_mode_src: assert property (p_prog_mode_src)
      else $error("tx empty mode changed without enable-view write");

   property p_div_high;
      wrIer && divisorAccessBit |-> ##[1:2] divisorValue[15:8] == wrHigh_r;
   endproperty
   a_div_high: assert property (p_div_high)
      else $error("divisor high byte not written");

   property p_div_keep;
      wrIer && !divisorAccessBit |=> $stable(divisorValue)[*2];
   endproperty
   a_div_keep: assert property (p_div_keep)
      else $error("enable-view write disturbed divisor");

   property p_dab_src;
      $changed(divisorAccessBit) |-> $past(wrLine) || $past(wrLine, 2);
   endproperty
   a_dab_src: assert property (p_dab_src)
      else $error("divisor access changed without line control write");

   property p_zero_stop;
      (divisorValue == 16'h0)[*4] |-> !serialEnable && !baudTick16;
   endproperty
   a_zero_stop: assert property (p_zero_stop)
      else $error("baud activity with zero divisor");

   property p_tick_gap;
      (divisorValue == 16'h3)[*6] ##0 baudTick16 |=> !baudTick16[*2]
         ##1 (baudTick16 || divisorValue != 16'h3);
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("oversample tick spacing differs from divisor");

   property p_run;
      (divisorValue != 16'h0)[*4] |-> serialEnable;
   endproperty
   a_run: assert property (p_run)
      else $error("serial enable low with nonzero divisor");

   property p_irq_id;
      irq == (intId != 3'h0);
   endproperty
   a_irq_id: assert property (p_irq_id)
      else $error("irq and interrupt id disagree");

   c_irq:  cover property (irq && intId == 3'h1);
   c_err:  cover property (pready && pslverr);
   c_tick: cover property (baudTick);
   c_dlh:  cover property (wrIer && divisorAccessBit);
endmodule : uart_ier_dlh_asserts

bind uart_ier_dlh uart_ier_dlh_asserts u_asserts (.clock, .reset, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
   .irq, .intId, .progTxEmptyModeEn, .divisorAccessBit, .divisorValue,
   .baudTick16, .baudTick, .serialEnable);

// ===== testbench/uart_ier_dlh_tb.sv
// Purpose: directed register and interrupt test of uart_ier_dlh
// Assumes: apb answers after one wait state, bench waits are bounded
// Notes:   event vector bits: rx data, tx empty, rx line, modem, timeout,
//          below threshold
`timescale 1ns/10ps
`include "uart_ier_consts.svh"
module uart_ier_dlh_tb;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, progTxEmptyModeEn, divisorAccessBit;
   logic        baudTick16, baudTick, serialEnable;
   logic [2:0]  intId;
   logic [15:0] divisorValue;
   logic [5:0]  evt = 6'h00;
   logic        fifoEnabled = 1'b0;
   logic        rxDataAvailEvt, txHoldEmpty, rxLineStatusEvt;
   logic        modemStatusEvt, charTimeoutEvt, txBelowThreshold;
   logic [7:0]  ierTab [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h01, 8'h82};
   logic [2:0]  idTab [6] = '{3'h2, 3'h3, 3'h1, 3'h4, 3'h2, 3'h3};
   int          clrBit [4] = '{2, 0, 1, 3};
   int          n_fail = 0;
   int          tests_run = 0;
   int          t16, t1;

   assign {txBelowThreshold, charTimeoutEvt, modemStatusEvt,
           rxLineStatusEvt, txHoldEmpty, rxDataAvailEvt} = evt;

   always #25 clock = ~clock;

   uart_ier_dlh uut (.clock, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .rxLineStatusEvt,
      .rxDataAvailEvt, .charTimeoutEvt, .fifoEnabled, .txHoldEmpty,
      .txBelowThreshold, .modemStatusEvt, .irq, .intId,
      .progTxEmptyModeEn, .divisorAccessBit, .divisorValue, .baudTick16,
      .baudTick, .serialEnable);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // entered just after a rising edge; one idle edge after release
   task automatic apb(input logic w, input logic [31:0] a, d,
                      output logic [31:0] q, output logic e);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         n_fail++;
         results();
      end
      @(posedge clock);
   endtask : apb

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] x,
                     input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      check(q, x);
      check(e, xe);
   endtask : rd

   task automatic count(input int n, output int c16, output int c1);
      c16 = 0;
      c1 = 0;
      repeat (n) begin
         @(posedge clock);
         c16 += (baudTick16 === 1'b1);
         c1 += (baudTick === 1'b1);
      end
   endtask : count

   task automatic pulse(input logic [5:0] v);
      evt <= v;
      @(posedge clock);
      evt <= 6'h00;
      repeat (3) @(posedge clock);
   endtask : pulse

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rd(`UART_ADDR_IER_DLH, 32'h0, 1'b0);
      check(serialEnable, 32'h0);
      wr(`UART_ADDR_IER_DLH, 32'hff);
      rd(`UART_ADDR_IER_DLH, 32'h8f, 1'b0);
      check(progTxEmptyModeEn, 32'h1);
      wr(`UART_ADDR_LINE_CTRL, 32'h80);
      // output flop follows the line control write one edge later
      @(posedge clock);
      check(divisorAccessBit, 32'h1);
      wr(`UART_ADDR_IER_DLH, 32'ha5);
      wr(`UART_ADDR_DIV_LOW, 32'h03);
      rd(`UART_ADDR_IER_DLH, 32'ha5, 1'b0);
      check(divisorValue, 32'ha503);
      wr(`UART_ADDR_LINE_CTRL, 32'h00);
      wr(`UART_ADDR_IER_DLH, 32'h0a);
      rd(`UART_ADDR_IER_DLH, 32'h0a, 1'b0);
      check(divisorValue, 32'ha503);
      check(progTxEmptyModeEn, 32'h0);
      rd(32'h5000_1020, 32'h0, 1'b1);
      // low divisor of 3 keeps the baud count short
      wr(`UART_ADDR_LINE_CTRL, 32'h80);
      wr(`UART_ADDR_IER_DLH, 32'h00);
      repeat (4) @(posedge clock);
      count(480, t16, t1);
      check(t16, 160);
      check(t1, 10);
      check(serialEnable, 32'h1);
      wr(`UART_ADDR_DIV_LOW, 32'h00);
      repeat (4) @(posedge clock);
      count(96, t16, t1);
      check(t16 + t1, 0);
      check(serialEnable, 32'h0);
      wr(`UART_ADDR_LINE_CTRL, 32'h00);
      wr(`UART_ADDR_IRQ_MASK, 32'hf);
      // timeout is ignored while the fifos are off
      wr(`UART_ADDR_IER_DLH, 32'h01);
      pulse(6'h10);
      check(irq, 32'h0);
      // threshold source is ignored while the programmable mode is off
      wr(`UART_ADDR_IER_DLH, 32'h02);
      pulse(6'h20);
      check(irq, 32'h0);
      fifoEnabled <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         for (int en = 0; en < 2; en++) begin
            wr(`UART_ADDR_IER_DLH, en ? ierTab[i] : 8'h00);
            pulse(6'h01 << i);
            check(irq, en);
            check(intId, en ? idTab[i] : 3'h0);
            wr(`UART_ADDR_IRQ_STAT, 32'hf);
            repeat (2) @(posedge clock);
            check(irq, 32'h0);
         end
      end
      wr(`UART_ADDR_IER_DLH, 32'h0f);
      pulse(6'h0f);
      for (int k = 0; k < 4; k++) begin
         check(intId, k + 1);
         wr(`UART_ADDR_IRQ_STAT, 32'h1 << clrBit[k]);
         repeat (2) @(posedge clock);
      end
      check(irq, 32'h0);
      wr(`UART_ADDR_IRQ_MASK, 32'h0);
      pulse(6'h08);
      check(irq, 32'h0);
      wr(`UART_ADDR_IRQ_MASK, 32'h8);
      repeat (3) @(posedge clock);
      check(intId, 32'h4);
      results();
   end
endmodule : uart_ier_dlh_tb
